//--- inc/oscc_pkg.sv
// Constants and types for the oscillator enable and stability block.
// Assumes a 125 MHz APB clock; register offsets are byte addresses.
package oscc_pkg;
    // Clock and stabilisation timing
    localparam int CLK_NS        = 8;
    localparam int RC_STABLE_NS  = 4000;
    localparam int XT_STABLE_NS  = 6000;
    localparam int RC_STABLE_CYC = (RC_STABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int XT_STABLE_CYC = (XT_STABLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W         = 10;

    // Register byte offsets
    localparam logic [7:0] OFF_HALT = 8'h00;
    localparam logic [7:0] OFF_RC   = 8'h04;
    localparam logic [7:0] OFF_XT   = 8'h08;
    localparam logic [7:0] OFF_STS  = 8'h0C;
    localparam logic [7:0] OFF_MSK  = 8'h10;
    localparam logic [7:0] OFF_MODE = 8'h14;

    // Field positions
    localparam int HALT_LS_BIT = 0;
    localparam int HALT_HS_BIT = 1;
    localparam int RC_EN_BIT   = 0;
    localparam int RC_FLG_BIT  = 1;
    localparam int RC_SEL_LSB  = 2;
    localparam int XT_EN_BIT   = 0;
    localparam int XT_FLG_BIT  = 1;
    localparam int XT_MODE_BIT = 2;
    localparam int EV_RC_BIT   = 0;
    localparam int EV_XT_BIT   = 1;

    // Reset values
    localparam logic [1:0] RC_SEL_RST = 2'h0;
    localparam logic       RC_EN_RST  = 1'b1;
    localparam logic       XT_EN_RST  = 1'b0;
    localparam logic       XT_MD_RST  = 1'b0;

    // Frequency codes in MHz
    localparam logic [4:0] MHZ_8  = 5'h08;
    localparam logic [4:0] MHZ_12 = 5'h0C;
    localparam logic [4:0] MHZ_16 = 5'h10;

    typedef enum logic [2:0] {
        OSCC_RUN, OSCC_SLEEP, OSCC_IDLE0, OSCC_IDLE1, OSCC_IDLE2
    } oscc_mode_t;

    typedef struct packed {
        logic [1:0] freq_sel;
        logic       enable;
    } oscc_rc_t;

    typedef struct packed {
        logic range_mode;
        logic enable;
    } oscc_xt_t;
endpackage

//--- hdl/oscc_top.sv
// Oscillator enable, frequency select and stability tracking over APB.
// Assumes the core pulses halt_req/wake_req synchronously to pclk.
`timescale 1ns/1ps
module oscc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    output logic             hs_osc_run,
    output logic             ls_osc_run,
    output logic             rc_osc_on,
    output logic      [4:0]  rc_freq_mhz,
    output logic             xt_osc_on,
    output logic             xt_range_out,
    output logic      [2:0]  halt_mode,
    output logic             irq
);
    localparam int CNT_W = oscc_pkg::CNT_W;
    localparam logic [CNT_W-1:0] RC_LOAD =
        CNT_W'(oscc_pkg::RC_STABLE_CYC);
    localparam logic [CNT_W-1:0] XT_LOAD =
        CNT_W'(oscc_pkg::XT_STABLE_CYC);

    oscc_pkg::oscc_rc_t   rc_q, rc_d;
    oscc_pkg::oscc_xt_t   xt_q, xt_d;
    oscc_pkg::oscc_mode_t mode_q, mode_d;
    logic             hs_keep_q, hs_keep_d, ls_keep_q, ls_keep_d;
    logic             rc_flg_q, rc_flg_d, xt_flg_q, xt_flg_d;
    logic [CNT_W-1:0] rc_cnt_q, rc_cnt_d, xt_cnt_q, xt_cnt_d;
    logic [1:0]       rc_appl_q, rc_appl_d;
    logic [1:0]       sts_q, sts_d, msk_q, msk_d;
    logic             rc_restart, xt_restart, wr_en, rd_en;
    logic [31:0]      rdat;
    logic             hit;

    // Bus strobes: one wait state, write lands with pready high
    assign wr_en = psel & penable & pwrite & pready;
    assign rd_en = psel & penable & ~pready;

    // Read mux; upper bits of each register stay zero
    always_comb begin
        rdat = 32'h0;
        hit  = 1'b1;
        case (paddr)
            oscc_pkg::OFF_HALT: begin
                rdat[oscc_pkg::HALT_LS_BIT] = ls_keep_q;
                rdat[oscc_pkg::HALT_HS_BIT] = hs_keep_q;
            end
            oscc_pkg::OFF_RC: begin
                rdat[oscc_pkg::RC_EN_BIT]  = rc_q.enable;
                rdat[oscc_pkg::RC_FLG_BIT] = rc_flg_q;
                rdat[oscc_pkg::RC_SEL_LSB +: 2] = rc_q.freq_sel;
            end
            oscc_pkg::OFF_XT: begin
                rdat[oscc_pkg::XT_EN_BIT]   = xt_q.enable;
                rdat[oscc_pkg::XT_FLG_BIT]  = xt_flg_q;
                rdat[oscc_pkg::XT_MODE_BIT] = xt_q.range_mode;
            end
            oscc_pkg::OFF_STS:  rdat[1:0] = sts_q;
            oscc_pkg::OFF_MSK:  rdat[1:0] = msk_q;
            oscc_pkg::OFF_MODE: rdat[2:0] = mode_q;
            default:            hit = 1'b0;
        endcase
    end

    // Register writes; flag bits are never written
    always_comb begin
        hs_keep_d = hs_keep_q;
        ls_keep_d = ls_keep_q;
        rc_d      = rc_q;
        xt_d      = xt_q;
        msk_d     = msk_q;
        if (wr_en) begin
            case (paddr)
                oscc_pkg::OFF_HALT: begin
                    ls_keep_d = pwdata[oscc_pkg::HALT_LS_BIT];
                    hs_keep_d = pwdata[oscc_pkg::HALT_HS_BIT];
                end
                oscc_pkg::OFF_RC: begin
                    rc_d.enable   = pwdata[oscc_pkg::RC_EN_BIT];
                    rc_d.freq_sel = pwdata[oscc_pkg::RC_SEL_LSB +: 2];
                end
                oscc_pkg::OFF_XT: begin
                    xt_d.enable     = pwdata[oscc_pkg::XT_EN_BIT];
                    xt_d.range_mode = pwdata[oscc_pkg::XT_MODE_BIT];
                end
                oscc_pkg::OFF_MSK: msk_d = pwdata[1:0];
                default: ;
            endcase
        end
    end

    // Stability timers; a disabled oscillator holds its flag low
    always_comb begin
        rc_restart = rc_d.enable &
            (~rc_q.enable | (rc_d.freq_sel != rc_q.freq_sel));
        xt_restart = xt_d.enable & ~xt_q.enable;
        rc_cnt_d = rc_cnt_q;
        rc_flg_d = rc_flg_q;
        xt_cnt_d = xt_cnt_q;
        xt_flg_d = xt_flg_q;
        if (!rc_d.enable) begin
            rc_cnt_d = RC_LOAD;
            rc_flg_d = 1'b0;
        end else if (rc_restart) begin
            rc_cnt_d = RC_LOAD;
            rc_flg_d = 1'b0;
        end else if (rc_cnt_q != '0) begin
            rc_cnt_d = rc_cnt_q - 1'b1;
            rc_flg_d = (rc_cnt_q == CNT_W'(1));
        end
        if (!xt_d.enable) begin
            xt_cnt_d = XT_LOAD;
            xt_flg_d = 1'b0;
        end else if (xt_restart) begin
            xt_cnt_d = XT_LOAD;
            xt_flg_d = 1'b0;
        end else if (xt_cnt_q != '0) begin
            xt_cnt_d = xt_cnt_q - 1'b1;
            xt_flg_d = (xt_cnt_q == CNT_W'(1));
        end
        // Old frequency holds until the oscillator has settled
        rc_appl_d = rc_flg_d ? rc_d.freq_sel : rc_appl_q;
    end

    // Sticky events; a new event wins over a same-cycle clear
    always_comb begin
        sts_d = sts_q;
        if (wr_en && paddr == oscc_pkg::OFF_STS)
            sts_d = sts_q & ~pwdata[1:0];
        sts_d[oscc_pkg::EV_RC_BIT] = sts_d[oscc_pkg::EV_RC_BIT] |
            (rc_flg_d & ~rc_flg_q);
        sts_d[oscc_pkg::EV_XT_BIT] = sts_d[oscc_pkg::EV_XT_BIT] |
            (xt_flg_d & ~xt_flg_q);
    end

    // Halt mode chosen from the keep bits at the halt
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            oscc_pkg::OSCC_RUN: begin
                if (halt_req) begin
                    case ({hs_keep_q, ls_keep_q})
                        2'b00:   mode_d = oscc_pkg::OSCC_SLEEP;
                        2'b01:   mode_d = oscc_pkg::OSCC_IDLE0;
                        2'b11:   mode_d = oscc_pkg::OSCC_IDLE1;
                        default: mode_d = oscc_pkg::OSCC_IDLE2;
                    endcase
                end
            end
            default: if (wake_req) mode_d = oscc_pkg::OSCC_RUN;
        endcase
    end

    // Control state registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_q      <= '{freq_sel: oscc_pkg::RC_SEL_RST,
                           enable: oscc_pkg::RC_EN_RST};
            xt_q      <= '{range_mode: oscc_pkg::XT_MD_RST,
                           enable: oscc_pkg::XT_EN_RST};
            hs_keep_q <= 1'b0;
            ls_keep_q <= 1'b0;
            rc_flg_q  <= 1'b0;
            xt_flg_q  <= 1'b0;
            rc_cnt_q  <= RC_LOAD;
            xt_cnt_q  <= XT_LOAD;
            rc_appl_q <= oscc_pkg::RC_SEL_RST;
            sts_q     <= 2'h0;
            msk_q     <= 2'h0;
            mode_q    <= oscc_pkg::OSCC_RUN;
        end else begin
            rc_q      <= rc_d;
            xt_q      <= xt_d;
            hs_keep_q <= hs_keep_d;
            ls_keep_q <= ls_keep_d;
            rc_flg_q  <= rc_flg_d;
            xt_flg_q  <= xt_flg_d;
            rc_cnt_q  <= rc_cnt_d;
            xt_cnt_q  <= xt_cnt_d;
            rc_appl_q <= rc_appl_d;
            sts_q     <= sts_d;
            msk_q     <= msk_d;
            mode_q    <= mode_d;
        end
    end

    // Outputs registered from next values so they track the state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata       <= 32'h0;
            pready       <= 1'b0;
            pslverr      <= 1'b0;
            hs_osc_run   <= oscc_pkg::RC_EN_RST;
            ls_osc_run   <= 1'b1;
            rc_osc_on    <= oscc_pkg::RC_EN_RST;
            rc_freq_mhz  <= oscc_pkg::MHZ_8;
            xt_osc_on    <= 1'b0;
            xt_range_out <= 1'b0;
            halt_mode    <= 3'h0;
            irq          <= 1'b0;
        end else begin
            pready  <= rd_en | (psel & penable & pwrite & ~pready);
            pslverr <= psel & penable & ~pready & ~hit;
            prdata  <= (rd_en && !pwrite) ? rdat : 32'h0;
            hs_osc_run <= (rc_d.enable | xt_d.enable) &
                (mode_d == oscc_pkg::OSCC_RUN | hs_keep_d);
            ls_osc_run <= (mode_d == oscc_pkg::OSCC_RUN) | ls_keep_d;
            rc_osc_on    <= rc_d.enable;
            xt_osc_on    <= xt_d.enable;
            xt_range_out <= xt_d.range_mode;
            case (rc_appl_d)
                2'b01:   rc_freq_mhz <= oscc_pkg::MHZ_12;
                2'b10:   rc_freq_mhz <= oscc_pkg::MHZ_16;
                default: rc_freq_mhz <= oscc_pkg::MHZ_8;
            endcase
            halt_mode <= mode_d;
            irq       <= |(sts_d & msk_d);
        end
    end

    // Checks kept beside the logic
    sequence s_rc_settle;
        !rc_flg_q ##[1:600] rc_flg_q;
    endsequence
    sequence s_xt_settle;
        !xt_flg_q ##[1:800] xt_flg_q;
    endsequence

    property p_hs_halt;
        @(posedge pclk) disable iff (!presetn)
        (mode_q != oscc_pkg::OSCC_RUN && !hs_keep_q) |-> !hs_osc_run;
    endproperty
    a_hs_halt: assert property (p_hs_halt)
        else $error("fast oscillator runs in halt without keep");

    property p_ls_halt;
        @(posedge pclk) disable iff (!presetn)
        (mode_q != oscc_pkg::OSCC_RUN) |-> (ls_osc_run == ls_keep_q);
    endproperty
    a_ls_halt: assert property (p_ls_halt)
        else $error("slow oscillator state wrong in halt");

    property p_sleep;
        @(posedge pclk) disable iff (!presetn)
        (halt_req && mode_q == oscc_pkg::OSCC_RUN && !hs_keep_q
         && !ls_keep_q) |=> (halt_mode == oscc_pkg::OSCC_SLEEP);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("halt with both keeps low did not sleep");

    property p_decode;
        @(posedge pclk) disable iff (!presetn)
        (rc_appl_q == 2'b11) |-> (rc_freq_mhz == oscc_pkg::MHZ_8);
    endproperty
    a_decode: assert property (p_decode)
        else $error("select 11 did not give 8MHz");

    property p_apply;
        @(posedge pclk) disable iff (!presetn)
        $changed(rc_freq_mhz) |-> rc_flg_q;
    endproperty
    a_apply: assert property (p_apply)
        else $error("frequency changed before stable");

    property p_rc_restart;
        @(posedge pclk) disable iff (!presetn || !rc_d.enable)
        rc_restart |=> s_rc_settle;
    endproperty
    a_rc_restart: assert property (p_rc_restart)
        else $error("RC stable flag sequence wrong");

    property p_xt_restart;
        @(posedge pclk) disable iff (!presetn || !xt_d.enable)
        xt_restart |=> s_xt_settle;
    endproperty
    a_xt_restart: assert property (p_xt_restart)
        else $error("crystal stable flag sequence wrong");

    property p_flags_off;
        @(posedge pclk) disable iff (!presetn)
        (!rc_osc_on |-> !rc_flg_q) and (!xt_osc_on |-> !xt_flg_q);
    endproperty
    a_flags_off: assert property (p_flags_off)
        else $error("stable flag high while disabled");

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        (pready && !pwrite && (paddr == oscc_pkg::OFF_RC
         || paddr == oscc_pkg::OFF_XT)) |-> (prdata[31:4] == 28'h0);
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unimplemented bits read nonzero");

    property p_range;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == oscc_pkg::OFF_XT) |=>
            (xt_range_out == $past(pwdata[oscc_pkg::XT_MODE_BIT]));
    endproperty
    a_range: assert property (p_range)
        else $error("crystal range not taken from write");
endmodule

//--- sim/testbench.sv
// Self-checking bench for the oscillator control block, driven over APB.
// Assumes the package constants for offsets, fields and settle counts.
`timescale 1ns/1ps
module testbench;
    logic        pclk     = 1'b0;
    logic        presetn  = 1'b0;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [7:0]  paddr    = 8'h00;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic        halt_req = 1'b0;
    logic        wake_req = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hs_osc_run;
    logic        ls_osc_run;
    logic        rc_osc_on;
    logic [4:0]  rc_freq_mhz;
    logic        xt_osc_on;
    logic        xt_range_out;
    logic [2:0]  halt_mode;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          bad_count = 0;
    int          n_checks  = 0;

    // One comparison, counted; mismatch reported at once
    `define CHK(got, exp) begin \
        n_checks++; \
        if ((got) !== (exp)) begin \
            bad_count++; \
            $display("Error t=%0t got %h exp %h", $time, got, exp); \
        end \
    end

    oscc_top oscc_top_inst (
        .pclk         (pclk),
        .presetn      (presetn),
        .psel         (psel),
        .penable      (penable),
        .pwrite       (pwrite),
        .paddr        (paddr),
        .pwdata       (pwdata),
        .prdata       (prdata),
        .pready       (pready),
        .pslverr      (pslverr),
        .halt_req     (halt_req),
        .wake_req     (wake_req),
        .hs_osc_run   (hs_osc_run),
        .ls_osc_run   (ls_osc_run),
        .rc_osc_on    (rc_osc_on),
        .rc_freq_mhz  (rc_freq_mhz),
        .xt_osc_on    (xt_osc_on),
        .xt_range_out (xt_range_out),
        .halt_mode    (halt_mode),
        .irq          (irq)
    );

    // 125 MHz bus clock
    always #4 pclk = ~pclk;

    // One APB transfer; waits for pready, the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rd, exp)
        `CHK(err, 1'b0)
    endtask

    // Core halt or wake pulse, one cycle wide
    task automatic pulse(input logic h);
        @(posedge pclk);
        halt_req <= h;
        wake_req <= ~h;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        #1;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run is about 3500 cycles; over five times that is a hang
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    initial begin
        logic [4:0]  fexp [4];
        logic [1:0]  sels [4];
        logic [2:0]  mexp [4];
        fexp = '{5'h0C, 5'h10, 5'h08, 5'h08};
        sels = '{2'h1, 2'h2, 2'h3, 2'h0};
        mexp = '{oscc_pkg::OSCC_SLEEP, oscc_pkg::OSCC_IDLE0,
                 oscc_pkg::OSCC_IDLE2, oscc_pkg::OSCC_IDLE1};
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // Power-on values; RC runs but is not yet settled
        rdchk(oscc_pkg::OFF_RC, 32'h0000_0001);
        rdchk(oscc_pkg::OFF_XT, 32'h0000_0000);
        rdchk(oscc_pkg::OFF_HALT, 32'h0000_0000);
        `CHK(rc_freq_mhz, oscc_pkg::MHZ_8)
        `CHK(xt_osc_on, 1'b0)
        repeat (oscc_pkg::RC_STABLE_CYC + 8) @(posedge pclk);
        rdchk(oscc_pkg::OFF_RC, 32'h0000_0003);
        rdchk(oscc_pkg::OFF_STS, 32'h0000_0001);
        `CHK(irq, 1'b0)
        // Unmask, then clear the sticky bit by writing one
        apb(1'b1, oscc_pkg::OFF_MSK, 32'h0000_0001);
        @(posedge pclk);
        #1;
        `CHK(irq, 1'b1)
        apb(1'b1, oscc_pkg::OFF_STS, 32'h0000_0001);
        @(posedge pclk);
        #1;
        `CHK(irq, 1'b0)
        rdchk(oscc_pkg::OFF_STS, 32'h0000_0000);
        // Every select code; junk in flag and upper bits must not stick
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, oscc_pkg::OFF_RC, {24'h0, 4'hF, sels[i], 2'b11});
            `CHK(rc_freq_mhz, (i == 0) ? oscc_pkg::MHZ_8 : fexp[i - 1])
            rdchk(oscc_pkg::OFF_RC, {28'h0, sels[i], 2'b01});
            repeat (oscc_pkg::RC_STABLE_CYC + 8) @(posedge pclk);
            rdchk(oscc_pkg::OFF_RC, {28'h0, sels[i], 2'b11});
            `CHK(rc_freq_mhz, fexp[i])
        end
        apb(1'b1, oscc_pkg::OFF_RC, 32'h0000_0000);
        rdchk(oscc_pkg::OFF_RC, 32'h0000_0000);
        `CHK(rc_osc_on, 1'b0)
        // RC settles above left bit0 set; clear it so bit1 stands alone
        apb(1'b1, oscc_pkg::OFF_STS, 32'h0000_0001);
        rdchk(oscc_pkg::OFF_STS, 32'h0000_0000);
        // Crystal: range set first, then enable
        apb(1'b1, oscc_pkg::OFF_XT, 32'h0000_0004);
        `CHK(xt_range_out, 1'b1)
        apb(1'b1, oscc_pkg::OFF_XT, 32'h0000_0005);
        rdchk(oscc_pkg::OFF_XT, 32'h0000_0005);
        `CHK(xt_osc_on, 1'b1)
        repeat (oscc_pkg::XT_STABLE_CYC + 8) @(posedge pclk);
        rdchk(oscc_pkg::OFF_XT, 32'h0000_0007);
        rdchk(oscc_pkg::OFF_STS, 32'h0000_0002);
        `CHK(irq, 1'b0)
        apb(1'b1, oscc_pkg::OFF_XT, 32'h0000_00FD);
        rdchk(oscc_pkg::OFF_XT, 32'h0000_0007);
        // Each keep-bit pair picks its halt mode and clock gating
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, oscc_pkg::OFF_HALT, k);
            pulse(1'b1);
            `CHK(halt_mode, mexp[k])
            `CHK(ls_osc_run, k[0])
            `CHK(hs_osc_run, k[1])
            rdchk(oscc_pkg::OFF_MODE, {29'h0, mexp[k]});
            pulse(1'b0);
            `CHK(halt_mode, 3'h0)
            `CHK(hs_osc_run, 1'b1)
        end
        // Unmapped place answers with an error and zero data
        apb(1'b0, 8'h18, 32'h0000_0000);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0000_0000)
        apb(1'b1, oscc_pkg::OFF_XT, 32'h0000_0004);
        rdchk(oscc_pkg::OFF_XT, 32'h0000_0004);
        end_of_test();
    end
endmodule
